// ### logic/acrc_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "acrc_params.svh"
module acrc_ctrl #(
    parameter int DATA_W = `ACRC_DATA_W,
    parameter int CONV_CYCLES = `ACRC_CONV_CYCLES,
    parameter int BURST_PAIRS = `ACRC_BURST_PAIRS,
    parameter int FIFO_DEPTH = `ACRC_OSR_DEPTH
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // mode straps
    input wire logic interface_select,
    input wire logic hw_mode,
    input wire logic write_burst,
    input wire logic [2:0] oversample_ratio_pins,
    // conversion control
    input wire logic convert_trigger,
    input wire logic [2:0] pair_select,
    output logic busy,
    // converter result source
    input wire logic [DATA_W-1:0] result_a,
    input wire logic [DATA_W-1:0] result_b,
    // host read pins
    input wire logic cs_n,
    input wire logic sclk_rd_n,
    // parallel bus
    input wire logic [DATA_W-1:0] parallel_bus_in,
    output logic [DATA_W-1:0] parallel_bus_out,
    output logic parallel_bus_oe,
    // serial outputs
    output logic serial_out_a,
    output logic serial_out_b,
    output logic serial_oe,
    // status
    output logic [2:0] pair_current,
    output logic burst_enabled,
    output logic serial_mode,
    output logic write_strobe,
    output logic [DATA_W-1:0] write_data
);
    // three-stage pin synchronisers
    logic [2:0] trig_s, cs_s, clk_s, wr_s;
    logic trig_rise, cs_fall, cs_low, clk_rise, rd_low, wr_rise;
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            trig_s <= 3'h0;
            cs_s <= 3'h7;
            clk_s <= 3'h7;
            wr_s <= 3'h7;
        end else begin
            trig_s <= {trig_s[1:0], convert_trigger};
            cs_s <= {cs_s[1:0], cs_n};
            clk_s <= {clk_s[1:0], sclk_rd_n};
            wr_s <= {wr_s[1:0], write_burst};
        end
    end
    assign trig_rise = trig_s[1] && !trig_s[2];
    assign cs_fall = !cs_s[1] && cs_s[2];
    assign cs_low = !cs_s[2] && !cs_s[1];
    assign clk_rise = clk_s[1] && !clk_s[2];
    assign rd_low = !clk_s[2] && !clk_s[1];
    assign wr_rise = wr_s[1] && !wr_s[2];

    // straps caught on the first clock after reset release
    logic armed_reg, armed_next, ser_reg, ser_next, hw_reg, hw_next, burst_reg, burst_next;
    logic [2:0] osr_reg, osr_next;
    always_comb begin
        armed_next = 1'b1;
        ser_next = ser_reg;
        hw_next = hw_reg;
        burst_next = burst_reg;
        osr_next = osr_reg;
        if (!armed_reg) begin
            ser_next = interface_select;
            hw_next = hw_mode;
            burst_next = hw_mode && write_burst;
            osr_next = hw_mode ? oversample_ratio_pins : 3'h0;
        end
    end
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            armed_reg <= 1'b0;
            ser_reg <= 1'b0;
            hw_reg <= 1'b0;
            burst_reg <= 1'b0;
            osr_reg <= 3'h0;
        end else begin
            armed_reg <= armed_next;
            ser_reg <= ser_next;
            hw_reg <= hw_next;
            burst_reg <= burst_next;
            osr_reg <= osr_next;
        end
    end
    assign burst_enabled = burst_reg;
    assign serial_mode = ser_reg;

    // software parallel write strobe
    logic wstb_reg, wstb_next;
    logic [DATA_W-1:0] wdat_reg, wdat_next;
    always_comb begin
        wstb_next = armed_reg && !hw_reg && !ser_reg && cs_low && wr_rise;
        wdat_next = wstb_next ? parallel_bus_in : wdat_reg;
    end
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            wstb_reg <= 1'b0;
            wdat_reg <= '0;
        end else begin
            wstb_reg <= wstb_next;
            wdat_reg <= wdat_next;
        end
    end
    assign write_strobe = wstb_reg;
    assign write_data = wdat_reg;

    // conversion sequencer
    acrc_pkg::acrc_conv_state_t st_reg, st_next;
    logic [15:0] cnt_reg, cnt_next;
    logic [7:0] left_reg, left_next;
    logic [2:0] pair_reg, pair_next;
    logic fifo_in_ready, fifo_out_valid;
    logic [2*DATA_W-1:0] fifo_out_data;
    logic fifo_push, fifo_pop;
    logic [7:0] total;
    always_comb begin
        total = burst_reg ? 8'(BURST_PAIRS) : 8'h01;
        if (osr_reg != 3'h0) begin
            total = 8'(BURST_PAIRS) << osr_reg[1:0];
        end
    end
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        left_next = left_reg;
        pair_next = pair_reg;
        fifo_push = 1'b0;
        case (st_reg)
            acrc_pkg::ACRC_IDLE: begin
                if (armed_reg && trig_rise) begin
                    st_next = acrc_pkg::ACRC_CONV;
                    cnt_next = 16'(CONV_CYCLES);
                    left_next = total;
                    pair_next = hw_reg ? pair_select : 3'h0;
                end
            end
            acrc_pkg::ACRC_CONV: begin
                if (cnt_reg > 16'h0001) begin
                    cnt_next = cnt_reg - 16'h0001;
                end else if (fifo_in_ready) begin
                    fifo_push = 1'b1;
                    if (left_reg == 8'h01) begin
                        st_next = acrc_pkg::ACRC_LOAD;
                    end else begin
                        left_next = left_reg - 8'h01;
                        cnt_next = 16'(CONV_CYCLES);
                        pair_next = pair_reg + 3'h1;
                    end
                end
            end
            acrc_pkg::ACRC_LOAD: begin
                st_next = acrc_pkg::ACRC_IDLE;
            end
            default: begin
                st_next = acrc_pkg::ACRC_IDLE;
            end
        endcase
    end
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            st_reg <= acrc_pkg::ACRC_IDLE;
            cnt_reg <= 16'h0000;
            left_reg <= 8'h00;
            pair_reg <= 3'h0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            left_reg <= left_next;
            pair_reg <= pair_next;
        end
    end
    assign busy = (st_reg == acrc_pkg::ACRC_CONV);
    assign pair_current = pair_reg;

    // result fifo
    acrc_fifo #(.WIDTH(2*DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .reset_n(reset_n),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data({result_a, result_b}),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // output registers and readout
    logic [DATA_W-1:0] sh_a_reg, sh_a_next, sh_b_reg, sh_b_next;
    logic pdrv_reg, pdrv_next, sdrv_reg, sdrv_next;
    logic [DATA_W-1:0] pout_reg, pout_next;
    logic [7:0] rd_cnt_reg, rd_cnt_next;
    logic rd_low_d;
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rd_low_d <= 1'b0;
        end else begin
            rd_low_d <= cs_low && rd_low;
        end
    end
    always_comb begin
        sh_a_next = sh_a_reg;
        sh_b_next = sh_b_reg;
        pout_next = pout_reg;
        rd_cnt_next = rd_cnt_reg;
        fifo_pop = 1'b0;
        pdrv_next = !ser_reg && cs_low && rd_low && !busy;
        sdrv_next = ser_reg && cs_low;
        if (ser_reg) begin
            if (cs_fall && fifo_out_valid && !busy) begin
                sh_a_next = fifo_out_data[2*DATA_W-1:DATA_W];
                sh_b_next = fifo_out_data[DATA_W-1:0];
                fifo_pop = 1'b1;
            end else if (cs_low && clk_rise) begin
                sh_a_next = {sh_a_reg[DATA_W-2:0], 1'b0};
                sh_b_next = {sh_b_reg[DATA_W-2:0], 1'b0};
            end
        end else if (pdrv_next && !rd_low_d && fifo_out_valid) begin
            pout_next = rd_cnt_reg[0] ? fifo_out_data[DATA_W-1:0] : fifo_out_data[2*DATA_W-1:DATA_W];
            fifo_pop = rd_cnt_reg[0];
            rd_cnt_next = rd_cnt_reg + 8'h01;
        end
    end
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sh_a_reg <= '0;
            sh_b_reg <= '0;
            pout_reg <= '0;
            rd_cnt_reg <= 8'h00;
            pdrv_reg <= 1'b0;
            sdrv_reg <= 1'b0;
        end else begin
            sh_a_reg <= sh_a_next;
            sh_b_reg <= sh_b_next;
            pout_reg <= pout_next;
            rd_cnt_reg <= rd_cnt_next;
            pdrv_reg <= pdrv_next;
            sdrv_reg <= sdrv_next;
        end
    end
    assign serial_out_a = sh_a_reg[DATA_W-1];
    assign serial_out_b = sh_b_reg[DATA_W-1];
    assign serial_oe = sdrv_reg;
    assign parallel_bus_out = pout_reg;
    assign parallel_bus_oe = pdrv_reg;

    // assertions
    property p_busy_rise;
        @(posedge clock) disable iff (!reset_n)
        (st_reg == acrc_pkg::ACRC_IDLE && armed_reg && trig_rise) |=> busy;
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy did not rise after trigger");
    property p_ignore;
        @(posedge clock) disable iff (!reset_n)
        (busy && trig_rise && left_reg > 8'h01) |=> $stable(pair_reg) || (left_reg == $past(left_reg) - 8'h01);
    endproperty
    a_ignore: assert property (p_ignore) else $error("trigger during busy restarted");
    property p_single;
        @(posedge clock) disable iff (!reset_n)
        (!busy && $past(busy) && !burst_reg && osr_reg == 3'h0) |-> $past(left_reg) == 8'h01;
    endproperty
    a_single: assert property (p_single) else $error("more than one pair per trigger");
    property p_par_oe;
        @(posedge clock) disable iff (!reset_n)
        parallel_bus_oe |-> !ser_reg && !$past(cs_s[2]);
    endproperty
    a_par_oe: assert property (p_par_oe) else $error("bus driven outside select");
    property p_ser_oe;
        @(posedge clock) disable iff (!reset_n)
        serial_oe |-> ser_reg && !parallel_bus_oe;
    endproperty
    a_ser_oe: assert property (p_ser_oe) else $error("serial enable in wrong mode");
    property p_shift;
        @(posedge clock) disable iff (!reset_n)
        (ser_reg && cs_low && clk_rise && !cs_fall) |=> serial_out_a == $past(sh_a_reg[DATA_W-2]);
    endproperty
    a_shift: assert property (p_shift) else $error("serial shift wrong");
    property p_strap;
        @(posedge clock) disable iff (!reset_n)
        armed_reg && $past(armed_reg) |-> $stable(burst_reg) && $stable(ser_reg);
    endproperty
    a_strap: assert property (p_strap) else $error("strap changed without reset");
    property p_pair;
        @(posedge clock) disable iff (!reset_n)
        (st_reg == acrc_pkg::ACRC_IDLE && armed_reg && trig_rise && hw_reg) |=> pair_reg == $past(pair_select);
    endproperty
    a_pair: assert property (p_pair) else $error("pair select not taken");
    property p_wstb;
        @(posedge clock) disable iff (!reset_n)
        write_strobe |-> !hw_reg && !ser_reg;
    endproperty
    a_wstb: assert property (p_wstb) else $error("write strobe in hardware mode");
    property p_msb_a;
        @(posedge clock) disable iff (!reset_n)
        (ser_reg && cs_fall && fifo_out_valid && !busy) |=> serial_out_a == $past(fifo_out_data[2*DATA_W-1]);
    endproperty
    a_msb_a: assert property (p_msb_a) else $error("line a msb not shown at select");
    property p_msb_b;
        @(posedge clock) disable iff (!reset_n)
        (ser_reg && cs_fall && fifo_out_valid && !busy) |=> serial_out_b == $past(fifo_out_data[DATA_W-1]);
    endproperty
    a_msb_b: assert property (p_msb_b) else $error("line b msb not shown at select");
    property p_par_busy;
        @(posedge clock) disable iff (!reset_n)
        busy |=> !parallel_bus_oe;
    endproperty
    a_par_busy: assert property (p_par_busy) else $error("bus enabled during conversion");
    c_conv: cover property (@(posedge clock) disable iff (!reset_n) $fell(busy));
    c_burst: cover property (@(posedge clock) disable iff (!reset_n) $fell(busy) && burst_reg);
    c_write: cover property (@(posedge clock) disable iff (!reset_n) write_strobe);
    c_ser: cover property (@(posedge clock) disable iff (!reset_n) fifo_pop && ser_reg);
    c_par: cover property (@(posedge clock) disable iff (!reset_n) fifo_pop && !ser_reg);
endmodule
`default_nettype wire

// ### logic/acrc_params.svh
`ifndef ACRC_PARAMS_SVH
`define ACRC_PARAMS_SVH
`define ACRC_DATA_W 16
`define ACRC_CONV_TIME_NS 500
`define ACRC_CLK_NS 100
`define ACRC_CONV_CYCLES ((`ACRC_CONV_TIME_NS + `ACRC_CLK_NS - 1) / `ACRC_CLK_NS)
`define ACRC_BURST_PAIRS 8
`define ACRC_OSR_DEPTH 16
`endif

// ### logic/acrc_pkg.sv
package acrc_pkg;
    typedef enum logic [1:0] {
        ACRC_IDLE,
        ACRC_CONV,
        ACRC_LOAD
    } acrc_conv_state_t;
endpackage

// ### logic/acrc_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module acrc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // write side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // read side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
    logic full, empty;
    assign full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
    assign empty = (wr_reg == rd_reg);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_reg[AW-1:0]];
    always_comb begin
        wr_next = wr_reg;
        rd_next = rd_reg;
        if (in_valid && !full) begin
            wr_next = wr_reg + 1'b1;
        end
        if (out_ready && !empty) begin
            rd_next = rd_reg + 1'b1;
        end
    end
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
        if (in_valid && !full) begin
            mem[wr_reg[AW-1:0]] <= in_data;
        end
    end
endmodule
`default_nettype wire

// ### bench/acrc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module acrc_host_model (
    // clock
    input wire logic clock,
    // host strobes
    output logic cs_n,
    output logic sclk_rd_n,
    // device outputs
    input wire logic serial_out_a,
    input wire logic serial_out_b,
    input wire logic serial_oe,
    input wire logic [15:0] parallel_bus_out,
    input wire logic parallel_bus_oe
);
    initial begin
        cs_n = 1'b1;
        sclk_rd_n = 1'b1;
    end
    // chip select held alone, for register writes
    task automatic select(input logic on);
        @(posedge clock);
        cs_n <= ~on;
    endtask
    // framed serial read, clock idles high and stands still outside frames
    task automatic read_serial(output logic [15:0] a, output logic [15:0] b, output logic oe);
        oe = 1'b1;
        @(posedge clock);
        cs_n <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            repeat (i == 15 ? 5 : 3) @(posedge clock);
            @(negedge clock);
            a[i] = serial_oe ? serial_out_a : ~serial_out_a;
            b[i] = serial_oe ? serial_out_b : ~serial_out_b;
            oe = oe & serial_oe;
            if (i > 0) begin
                @(posedge clock);
                sclk_rd_n <= 1'b0;
                repeat (4) @(posedge clock);
                sclk_rd_n <= 1'b1;
            end
        end
        @(posedge clock);
        cs_n <= 1'b1;
    endtask
    // one parallel access, read strobe optional
    task automatic read_par(input logic rd, output logic [15:0] d, output logic oe);
        @(posedge clock);
        cs_n <= 1'b0;
        sclk_rd_n <= ~rd;
        repeat (4) @(posedge clock);
        @(negedge clock);
        d = parallel_bus_oe ? parallel_bus_out : ~parallel_bus_out;
        oe = parallel_bus_oe;
        @(posedge clock);
        cs_n <= 1'b1;
        sclk_rd_n <= 1'b1;
        repeat (4) @(posedge clock);
    endtask
endmodule
`default_nettype wire

// ### bench/acrc_ctrl_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "acrc_params.svh"
module acrc_ctrl_tb_top;
    typedef struct packed {logic [2:0] sel; logic [15:0] a; logic [15:0] b;} acrc_row_t;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic interface_select = 1'b0;
    logic hw_mode = 1'b1;
    logic write_burst = 1'b0;
    logic [2:0] oversample_ratio_pins = 3'h0;
    logic convert_trigger = 1'b0;
    logic [2:0] pair_select = 3'h0;
    logic [15:0] result_a = 16'h0000;
    logic [15:0] result_b = 16'h0000;
    logic [15:0] parallel_bus_in = 16'h0000;
    logic cs_n, sclk_rd_n, busy, serial_out_a, serial_out_b, serial_oe;
    logic parallel_bus_oe, burst_enabled, serial_mode, write_strobe;
    logic [15:0] parallel_bus_out, write_data;
    logic [2:0] pair_current;
    int num_errors = 0;
    int num_checks = 0;

    always #50 clock = ~clock;

    acrc_ctrl u_dut (
        .clock(clock), .reset_n(reset_n), .interface_select(interface_select), .hw_mode(hw_mode),
        .write_burst(write_burst), .oversample_ratio_pins(oversample_ratio_pins),
        .convert_trigger(convert_trigger), .pair_select(pair_select), .busy(busy),
        .result_a(result_a), .result_b(result_b), .cs_n(cs_n), .sclk_rd_n(sclk_rd_n),
        .parallel_bus_in(parallel_bus_in), .parallel_bus_out(parallel_bus_out),
        .parallel_bus_oe(parallel_bus_oe), .serial_out_a(serial_out_a), .serial_out_b(serial_out_b),
        .serial_oe(serial_oe), .pair_current(pair_current), .burst_enabled(burst_enabled),
        .serial_mode(serial_mode), .write_strobe(write_strobe), .write_data(write_data)
    );

    acrc_host_model u_host (
        .clock(clock), .cs_n(cs_n), .sclk_rd_n(sclk_rd_n), .serial_out_a(serial_out_a),
        .serial_out_b(serial_out_b), .serial_oe(serial_oe), .parallel_bus_out(parallel_bus_out),
        .parallel_bus_oe(parallel_bus_oe)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic do_reset(input logic ifs, input logic hw, input logic wb);
        @(posedge clock);
        reset_n <= 1'b0;
        interface_select <= ifs;
        hw_mode <= hw;
        write_burst <= wb;
        pair_select <= hw ? pair_select : 3'h0;
        oversample_ratio_pins <= hw ? oversample_ratio_pins : 3'h0;
        repeat (1) @(posedge clock);
        @(negedge clock);
        check({busy, parallel_bus_oe, serial_oe}, 3'h0);
        @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
    endtask

    // one trigger edge; hi returns the busy width, retrig adds an edge mid-busy
    task automatic convert(output int hi, input logic retrig);
        int w;
        hi = 0;
        w = 0;
        @(posedge clock);
        convert_trigger <= 1'b1;
        do begin
            @(negedge clock);
            w++;
        end while (busy !== 1'b1 && w < 8);
        check(busy, 1'b1);
        while (busy === 1'b1 && hi < 400) begin
            @(posedge clock);
            if (retrig && hi == 2) convert_trigger <= 1'b0;
            if (retrig && hi == 6) convert_trigger <= 1'b1;
            @(negedge clock);
            hi++;
        end
        @(posedge clock);
        convert_trigger <= 1'b0;
    endtask

    initial begin
        #2000000;
        num_errors++;
        close_out();
    end

    initial begin
        logic [15:0] d, a, b;
        logic oe;
        int hi;
        acrc_row_t rows [4];
        rows = '{'{3'h0, 16'h0001, 16'hFFFE}, '{3'h1, 16'h8000, 16'h7FFF},
                 '{3'h5, 16'hA5A5, 16'h5A5A}, '{3'h7, 16'hFFFF, 16'h0000}};
        do_reset(1'b0, 1'b1, 1'b0);
        check({serial_mode, burst_enabled}, 2'h0);
        foreach (rows[i]) begin
            @(posedge clock);
            pair_select <= rows[i].sel;
            result_a <= rows[i].a;
            result_b <= rows[i].b;
            convert(hi, 1'b0);
            check(hi >= 5 && hi <= 7, 1'b1);
            check(pair_current, rows[i].sel);
            @(posedge clock);
            result_a <= ~rows[i].a;
            result_b <= ~rows[i].b;
            u_host.read_par(1'b0, d, oe);
            check(oe, 1'b0);
            u_host.read_par(1'b1, d, oe);
            check({oe, d}, {1'b1, rows[i].a});
            check(parallel_bus_oe, 1'b0);
            u_host.read_par(1'b1, d, oe);
            check({oe, d}, {1'b1, rows[i].b});
        end
        $display("test parallel rows done");

        do_reset(1'b0, 1'b1, 1'b1);
        @(posedge clock);
        write_burst <= 1'b0;
        result_a <= 16'h1111;
        result_b <= 16'h2222;
        convert(hi, 1'b1);
        check(burst_enabled, 1'b1);
        check(hi >= 40 && hi <= 60, 1'b1);
        repeat (10) begin
            @(negedge clock);
            check(busy, 1'b0);
        end
        @(posedge clock);
        result_a <= 16'h3333;
        result_b <= 16'h4444;
        convert(hi, 1'b0);
        for (int k = 0; k < 16; k++) begin
            u_host.read_par(1'b1, a, oe);
            u_host.read_par(1'b1, b, oe);
            check({a, b}, k < 8 ? 32'h11112222 : 32'h33334444);
        end
        $display("test burst fifo done");

        do_reset(1'b0, 1'b0, 1'b1);
        check(burst_enabled, 1'b0);
        u_host.select(1'b1);
        @(posedge clock);
        parallel_bus_in <= 16'hA5C3;
        write_burst <= 1'b0;
        repeat (2) @(posedge clock);
        write_burst <= 1'b1;
        hi = 0;
        repeat (8) begin
            @(negedge clock);
            if (write_strobe === 1'b1) begin
                hi++;
                d = write_data;
            end
        end
        check(hi, 1);
        check(d, 16'hA5C3);
        u_host.select(1'b0);
        @(posedge clock);
        parallel_bus_in <= 16'h5A3C;
        write_burst <= 1'b0;
        repeat (4) @(posedge clock);
        write_burst <= 1'b1;
        repeat (8) @(negedge clock);
        check({write_strobe, write_data}, {1'b0, 16'hA5C3});
        $display("test write strobe done");

        @(posedge clock);
        oversample_ratio_pins <= 3'h1;
        result_a <= 16'h0F0F;
        result_b <= 16'hF0F0;
        do_reset(1'b1, 1'b1, 1'b0);
        convert(hi, 1'b0);
        check(hi, 2 * `ACRC_BURST_PAIRS * `ACRC_CONV_CYCLES);
        u_host.read_serial(a, b, oe);
        check(oe, 1'b1);
        check({a, b}, 32'h0F0FF0F0);
        $display("test oversampling done");

        do_reset(1'b1, 1'b0, 1'b0);
        check({serial_mode, serial_oe}, 2'h2);
        @(posedge clock);
        interface_select <= 1'b0;
        for (int j = 0; j < 2; j++) begin
            @(posedge clock);
            result_a <= j ? 16'hC35A : 16'h8001;
            result_b <= j ? 16'h3CA5 : 16'h7FFE;
            convert(hi, 1'b0);
            check(serial_mode, 1'b1);
            u_host.read_serial(a, b, oe);
            check(oe, 1'b1);
            check({a, b}, j ? 32'hC35A3CA5 : 32'h80017FFE);
            repeat (4) @(negedge clock);
            check(serial_oe, 1'b0);
        end
        $display("test serial done");
        close_out();
    end
endmodule
`default_nettype wire
